//--- rtl/rcp_cfg.svh
// Register offsets, field positions and reset values of the rail pin logic
`ifndef RCP_CFG_SVH
`define RCP_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RCP_OFF_CTLMAP0  8'h00
`define RCP_OFF_CTLMAP3  8'h0C
`define RCP_OFF_SLPCFG   8'h10
`define RCP_OFF_SLPMAP   8'h14
`define RCP_OFF_SLPVSEL  8'h18
`define RCP_OFF_GPOCFG   8'h1C
`define RCP_OFF_PGMASK0  8'h20
`define RCP_OFF_PGMASK3  8'h2C
`define RCP_OFF_STATUS   8'h30
`define RCP_OFF_IRQSTAT  8'h34
`define RCP_OFF_IRQMASK  8'h38

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RCP_GPOCFG_SRC   0
`define RCP_GPOCFG_PP    4
`define RCP_GPOCFG_USER  8
`define RCP_STAT_PG      0
`define RCP_STAT_EN      8
`define RCP_STAT_SLP     16
`define RCP_STAT_GPIN    24
`define RCP_STAT_IRQIN   28
`define RCP_IRQ_SLPIN    8
`define RCP_IRQ_SLPOUT   9

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RCP_RST_WORD     32'h0000_0000
`define RCP_RST_NIB      4'h0
`define RCP_RST_IRQ      16'h0000

`endif

//--- rtl/rcp_pkg.sv
// Shared types of the rail pin logic
package rcp_pkg;

  // ----------------------------------------------------------------------
  // Bus word and output source choice
  // ----------------------------------------------------------------------
  typedef logic [31:0] rcp_word_t;
  typedef logic [15:0] rcp_irq_t;

  typedef enum logic [1:0] {
    RCP_SRC_PG  = 2'b01,
    RCP_SRC_REG = 2'b10
  } rcp_src_t;

endpackage : rcp_pkg

//--- rtl/rcp_gpo_if.sv
// Configuration bundle from the register file to one output driver
`timescale 1ns/1ps
`default_nettype none

interface rcp_gpo_if #(parameter int N = 8);
  logic [N-1:0] pgMask;
  logic         srcReg;
  logic         pushPull;
  logic         userBit;

  modport cfg (output pgMask, output srcReg, output pushPull, output userBit);
  modport drv (input pgMask, input srcReg, input pushPull, input userBit);
endinterface : rcp_gpo_if

`default_nettype wire

//--- rtl/rcp_gpo_drive.sv
// One general purpose output: source select and pin driver style
`timescale 1ns/1ps
`default_nettype none

module rcp_gpo_drive #(
  parameter int N       = 8,
  parameter bit OD_ONLY = 1'b0
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  rcp_gpo_if.drv            cfg,
  input  wire logic [N-1:0] powerGood,
  output logic              pinOut,
  output logic              pinOe
);
  import rcp_pkg::*;

  typedef struct packed {
    logic level;
    logic pp;
  } rcp_gpo_st_t;

  rcp_gpo_st_t q;
  rcp_gpo_st_t d;
  rcp_src_t    src;
  logic        allGood;

  // ----------------------------------------------------------------------
  // Source and level
  // ----------------------------------------------------------------------
  // Empty mask reads as good: no chosen rail can be bad
  always_comb begin
    allGood = &(powerGood | ~cfg.pgMask);
    src     = cfg.srcReg ? RCP_SRC_REG : RCP_SRC_PG;
    d       = q;
    case (src)
      RCP_SRC_REG: d.level = cfg.userBit;
      default:     d.level = allGood;
    endcase
    d.pp = OD_ONLY ? 1'b0 : cfg.pushPull;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Open drain only pulls low; a high level releases the pin
  assign pinOut = q.pp ? q.level : 1'b0;
  assign pinOe  = q.pp | ~q.level;

endmodule : rcp_gpo_drive

`default_nettype wire

//--- rtl/rcp_rail_ctrl.sv
// Regulator group enable and sleep decode from the control inputs
`timescale 1ns/1ps
`default_nettype none

module rcp_rail_ctrl #(
  parameter int N = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [3:0]        ctlLevel,
  input  wire logic [3:0][N-1:0] ctlMap,
  input  wire logic              sleepMode,
  input  wire logic [N-1:0]      sleepMap,
  input  wire logic [N-1:0]      sleepVolt,
  output logic      [N-1:0]      regEnable,
  output logic      [N-1:0]      regSleep,
  output logic      [N-1:0]      regSleepVolt
);
  import rcp_pkg::*;

  typedef struct packed {
    logic [N-1:0] en;
    logic [N-1:0] slp;
    logic [N-1:0] vsel;
  } rcp_rail_st_t;

  rcp_rail_st_t q;
  rcp_rail_st_t d;
  logic [3:0]   enSrc;
  logic         sleepReq;

  // ----------------------------------------------------------------------
  // Group decode
  // ----------------------------------------------------------------------
  // Input index 1 is the third control pin; in sleep mode it stops enabling
  always_comb begin
    enSrc    = ctlLevel;
    enSrc[1] = ctlLevel[1] & ~sleepMode;
    sleepReq = sleepMode & ~ctlLevel[1];
    d        = q;
    d.en     = '0;
    for (int k = 0; k < 4; k++) begin
      d.en = d.en | (ctlMap[k] & {N{enSrc[k]}});
    end
    d.slp  = sleepMap & {N{sleepReq}};
    d.vsel = d.slp & sleepVolt;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign regEnable    = q.en;
  assign regSleep     = q.slp;
  assign regSleepVolt = q.vsel;

endmodule : rcp_rail_ctrl

`default_nettype wire

//--- rtl/rcp_rail_pins.sv
// Top of the rail control pin logic with its register file on APB
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rcp_cfg.svh"

module rcp_rail_pins #(
  parameter int N  = 8,
  parameter int AW = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [AW-1:0]     paddr,
  input  wire rcp_pkg::rcp_word_t pwdata,
  output rcp_pkg::rcp_word_t     prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              railCtrlIn2,
  input  wire logic              railCtrlIn3SleepN,
  input  wire logic              railCtrlIn4Prog,
  input  wire logic              railCtrlIn5,
  input  wire logic [N-1:0]      regPowerGood,
  output logic      [N-1:0]      regEnable,
  output logic      [N-1:0]      regSleep,
  output logic      [N-1:0]      regSleepVolt,
  input  wire logic              gpOutput1In,
  output logic                   gpOutput1Out,
  output logic                   gpOutput1Oe,
  input  wire logic              gpOutput2In,
  output logic                   gpOutput2Out,
  output logic                   gpOutput2Oe,
  input  wire logic              gpOutput3In,
  output logic                   gpOutput3Out,
  output logic                   gpOutput3Oe,
  input  wire logic              gpOutput4OdIn,
  output logic                   gpOutput4OdOut,
  output logic                   gpOutput4OdOe,
  input  wire logic              interruptOutNIn,
  output logic                   interruptOutNOut,
  output logic                   interruptOutNOe
);
  import rcp_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0][N-1:0] ctlMap;
    logic              sleepMode;
    logic [N-1:0]      sleepMap;
    logic [N-1:0]      sleepVolt;
    logic [3:0]        gpoSrc;
    logic [3:0]        gpoPp;
    logic [3:0]        gpoUser;
    logic [3:0][N-1:0] pgMask;
    rcp_irq_t          irqStat;
    rcp_irq_t          irqMask;
    rcp_word_t         rdData;
    logic              rdErr;
    logic [N-1:0]      pgPrev;
    logic              slpPrev;
    logic              irqLine;
  } rcp_top_st_t;

  rcp_top_st_t  q;
  rcp_top_st_t  d;

  logic         setupPh;
  logic         accessPh;
  logic         rdClear;
  logic         sleepAny;
  rcp_irq_t     events;
  rcp_irq_t     clrMask;
  rcp_word_t    rdWord;
  logic         rdHit;
  logic [3:0]   gpoOut;
  logic [3:0]   gpoOe;
  logic [3:0]   gpoIn;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // True when the address falls in a four-register array starting at base
  function automatic logic inBank(input logic [AW-1:0] a,
                                  input logic [AW-1:0] base);
    inBank = (a[AW-1:4] == base[AW-1:4]);
  endfunction : inBank

  // Widen a rail-sized field into the low bits of a bus word
  function automatic rcp_word_t railWord(input logic [N-1:0] v);
    railWord        = '0;
    railWord[N-1:0] = v;
  endfunction : railWord

  // ----------------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------------
  // Zero wait states: read data is fetched in the setup cycle
  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign pready   = 1'b1;
  assign prdata   = q.rdData;
  assign pslverr  = accessPh & q.rdErr;

  // Pin readback as seen through the board, for the status word
  assign gpoIn = {gpOutput4OdIn, gpOutput3In, gpOutput2In, gpOutput1In};

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  // Unmapped offsets read zero and answer with a slave error
  always_comb begin
    rdWord = '0;
    rdHit  = 1'b1;
    // Only paddr[3:2] picks a word inside a bank; low bits are ignored
    if (inBank(paddr, `RCP_OFF_CTLMAP0)) begin
      rdWord = railWord(q.ctlMap[paddr[3:2]]);
    end else if (paddr == `RCP_OFF_SLPCFG) begin
      rdWord[0] = q.sleepMode;
    end else if (paddr == `RCP_OFF_SLPMAP) begin
      rdWord = railWord(q.sleepMap);
    end else if (paddr == `RCP_OFF_SLPVSEL) begin
      rdWord = railWord(q.sleepVolt);
    end else if (paddr == `RCP_OFF_GPOCFG) begin
      rdWord[`RCP_GPOCFG_SRC +: 4]  = q.gpoSrc;
      rdWord[`RCP_GPOCFG_PP +: 4]   = q.gpoPp;
      rdWord[`RCP_GPOCFG_USER +: 4] = q.gpoUser;
    end else if (inBank(paddr, `RCP_OFF_PGMASK0)) begin
      rdWord = railWord(q.pgMask[paddr[3:2]]);
    end else if (paddr == `RCP_OFF_STATUS) begin
      rdWord[`RCP_STAT_PG +: N]    = regPowerGood;
      rdWord[`RCP_STAT_EN +: N]    = regEnable;
      rdWord[`RCP_STAT_SLP +: N]   = regSleep;
      rdWord[`RCP_STAT_GPIN +: 4]  = gpoIn;
      rdWord[`RCP_STAT_IRQIN]      = interruptOutNIn;
    end else if (paddr == `RCP_OFF_IRQSTAT) begin
      rdWord[15:0] = q.irqStat;
    end else if (paddr == `RCP_OFF_IRQMASK) begin
      rdWord[15:0] = q.irqMask;
    end else begin
      rdHit = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Next state: writes, events, read-clear
  // ----------------------------------------------------------------------
  always_comb begin
    d         = q;
    rdClear   = 1'b0;
    // Histories reset low: only a fall of power-good counts, so start-up
    // with every rail good raises no event
    d.pgPrev  = regPowerGood;
    d.slpPrev = sleepAny;

    // Power-good loss per rail, sleep entry and exit
    events                  = '0;
    events[N-1:0]           = q.pgPrev & ~regPowerGood;
    events[`RCP_IRQ_SLPIN]  = sleepAny & ~q.slpPrev;
    events[`RCP_IRQ_SLPOUT] = ~sleepAny & q.slpPrev;

    // Capture read data and error in setup, so access needs no wait state.
    // Writes capture zero, so a stale read word never lingers on prdata.
    if (setupPh) begin
      d.rdData = pwrite ? '0 : rdWord;
      d.rdErr  = ~rdHit;
    end

    // Writes land at the access edge; status words are read-only and
    // writes to them are dropped without an error
    if (accessPh && pwrite) begin
      if (inBank(paddr, `RCP_OFF_CTLMAP0)) begin
        d.ctlMap[paddr[3:2]] = pwdata[N-1:0];
      end else if (paddr == `RCP_OFF_SLPCFG) begin
        d.sleepMode = pwdata[0];
      end else if (paddr == `RCP_OFF_SLPMAP) begin
        d.sleepMap = pwdata[N-1:0];
      end else if (paddr == `RCP_OFF_SLPVSEL) begin
        d.sleepVolt = pwdata[N-1:0];
      end else if (paddr == `RCP_OFF_GPOCFG) begin
        d.gpoSrc  = pwdata[`RCP_GPOCFG_SRC +: 4];
        d.gpoPp   = pwdata[`RCP_GPOCFG_PP +: 4];
        d.gpoUser = pwdata[`RCP_GPOCFG_USER +: 4];
      end else if (inBank(paddr, `RCP_OFF_PGMASK0)) begin
        d.pgMask[paddr[3:2]] = pwdata[N-1:0];
      end else if (paddr == `RCP_OFF_IRQMASK) begin
        d.irqMask = pwdata[15:0];
      end
    end

    // The clear is taken at the access edge of an interrupt status read
    if (accessPh && !pwrite && paddr == `RCP_OFF_IRQSTAT) begin
      rdClear = 1'b1;
    end

    // Only bits the reader was shown are cleared: an event that arrived in
    // the setup cycle is not yet in the captured word and must stay pending.
    // A new event in the clearing cycle survives the clear as well.
    clrMask   = rdClear ? q.rdData[15:0] : '0;
    d.irqStat = (q.irqStat & ~clrMask) | events;
    // Mask of this cycle gates the line; a mask write shows one edge later
    d.irqLine = |(d.irqStat & q.irqMask);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // All block state in one register; sub-blocks keep their own
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q         <= '0;
      q.rdData  <= `RCP_RST_WORD;
      q.gpoSrc  <= `RCP_RST_NIB;
      q.irqMask <= `RCP_RST_IRQ;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Regulator groups
  // ----------------------------------------------------------------------
  // Input order: second, third, fourth, fifth control pins
  // Maps and sleep settings come straight from the register state
  rcp_rail_ctrl #(
    .N            (N)
  ) uRail (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .ctlLevel     ({railCtrlIn5, railCtrlIn4Prog,
                    railCtrlIn3SleepN, railCtrlIn2}),
    .ctlMap       (q.ctlMap),
    .sleepMode    (q.sleepMode),
    .sleepMap     (q.sleepMap),
    .sleepVolt    (q.sleepVolt),
    .regEnable    (regEnable),
    .regSleep     (regSleep),
    .regSleepVolt (regSleepVolt)
  );

  // Any sleeping rail counts for the entry and exit events
  assign sleepAny = |regSleep;

  // ----------------------------------------------------------------------
  // General purpose outputs
  // ----------------------------------------------------------------------
  // The last driver is built open-drain only; its push-pull bit is ignored
  for (genvar g = 0; g < 4; g++) begin : gGpo
    rcp_gpo_if #(.N(N)) gpoBus ();

    assign gpoBus.pgMask   = q.pgMask[g];
    assign gpoBus.srcReg   = q.gpoSrc[g];
    assign gpoBus.pushPull = q.gpoPp[g];
    assign gpoBus.userBit  = q.gpoUser[g];

    rcp_gpo_drive #(
      .N         (N),
      .OD_ONLY   (g == 3)
    ) uDrv (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .cfg       (gpoBus.drv),
      .powerGood (regPowerGood),
      .pinOut    (gpoOut[g]),
      .pinOe     (gpoOe[g])
    );
  end

  // Driver index k serves output pin k+1
  assign gpOutput1Out   = gpoOut[0];
  assign gpOutput1Oe    = gpoOe[0];
  assign gpOutput2Out   = gpoOut[1];
  assign gpOutput2Oe    = gpoOe[1];
  assign gpOutput3Out   = gpoOut[2];
  assign gpOutput3Oe    = gpoOe[2];
  assign gpOutput4OdOut = gpoOut[3];
  assign gpOutput4OdOe  = gpoOe[3];

  // ----------------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------------
  // Pull-low only, so a programming supply on the pin is never fought
  assign interruptOutNOut = 1'b0;
  assign interruptOutNOe  = q.irqLine;

endmodule : rcp_rail_pins

`default_nettype wire

//--- test/rcp_pin_host.sv
// Host side of the pins: board pull-ups and an outside regulator enable
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Pin resolution seen by the host
// ----------------------------------------------------------------------
module rcp_pin_host (
  input  wire logic [3:0] gpOut,
  input  wire logic [3:0] gpOe,
  input  wire logic       irqOut,
  input  wire logic       irqOe,
  output logic      [3:0] gpLevel,
  output logic            irqLevel,
  output logic            progLevel,
  output logic            extRegEn
);
  // Pull-ups win whenever the device lets go of a pin
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      gpLevel[k] = gpOe[k] ? gpOut[k] : 1'b1;
    end
    irqLevel = irqOe ? irqOut : 1'b1;
  end
  // Programming supply never applied; rails never mapped to it
  assign progLevel = 1'b0;
  // First output switches an outside regulator
  assign extRegEn = gpLevel[0];
endmodule : rcp_pin_host

`default_nettype wire

//--- test/rcp_rail_pins_chk.sv
// Port checker of the rail pin logic, bound to its top
`timescale 1ns/1ps
`default_nettype none
`include "rcp_cfg.svh"

// ----------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------
module rcp_rail_pins_chk #(
  parameter int N  = 8,
  parameter int AW = 8
) (
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [AW-1:0]      paddr,
  input wire rcp_pkg::rcp_word_t pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               railCtrlIn2,
  input wire logic               railCtrlIn3SleepN,
  input wire logic               railCtrlIn4Prog,
  input wire logic               railCtrlIn5,
  input wire logic [N-1:0]       regEnable,
  input wire logic [N-1:0]       regSleep,
  input wire logic [N-1:0]       regSleepVolt,
  input wire logic               gpOutput4OdOut,
  input wire logic               interruptOutNOut,
  input wire logic               interruptOutNOe
);
  import rcp_pkg::*;
  logic [N-1:0] map0_q;
  logic [N-1:0] slpMap_q;
  logic         slpCfg_q;
  logic [15:0]  irqMask_q;
  logic         wrHit;

  assign wrHit = psel & penable & pwrite;
  // Shadow of the settings the properties depend on
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      map0_q    <= '0;
      slpMap_q  <= '0;
      slpCfg_q  <= 1'b0;
      irqMask_q <= 16'h0000;
    end else if (wrHit) begin
      if (paddr == `RCP_OFF_CTLMAP0) map0_q <= pwdata[N-1:0];
      if (paddr == `RCP_OFF_SLPMAP) slpMap_q <= pwdata[N-1:0];
      if (paddr == `RCP_OFF_SLPCFG) slpCfg_q <= pwdata[0];
      if (paddr == `RCP_OFF_IRQMASK) irqMask_q <= pwdata[15:0];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence sleepReq;
    slpCfg_q && !railCtrlIn3SleepN;
  endsequence
  sequence maskOff;
    (irqMask_q == 16'h0000) [*2];
  endsequence

  AST_RAIL_CTRL_IN_2_ON: assert property (railCtrlIn2 |=>
    (regEnable & $past(map0_q)) == $past(map0_q)) else $error("group off");
  AST_ALL_OFF: assert property (!railCtrlIn2 && !railCtrlIn4Prog
    && !railCtrlIn5 && (slpCfg_q || !railCtrlIn3SleepN) |=> regEnable == '0)
    else $error("rail left on");
  AST_SLP_IN: assert property (sleepReq |=> regSleep == $past(slpMap_q))
    else $error("sleep set wrong");
  AST_SLP_OUT: assert property (slpCfg_q && railCtrlIn3SleepN
    |=> regSleep == '0) else $error("sleep not left");
  AST_SLP_VOLT: assert property ((regSleepVolt & ~regSleep) == '0)
    else $error("sleep voltage while awake");
  AST_GP4_OD: assert property (gpOutput4OdOut == 1'b0)
    else $error("output four drives high");
  AST_IRQ_OD: assert property (interruptOutNOut == 1'b0)
    else $error("interrupt drives high");
  AST_IRQ_MASK: assert property (maskOff |-> !interruptOutNOe)
    else $error("masked interrupt shown");
  AST_APB_ERR: assert property (psel && penable
    && paddr > `RCP_OFF_IRQMASK |-> pslverr) else $error("no slave error");
  AST_APB_RDY: assert property (psel && !penable |=> pready)
    else $error("access not ready");
endmodule : rcp_rail_pins_chk

bind rcp_rail_pins rcp_rail_pins_chk #(.N(N), .AW(AW)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .railCtrlIn2(railCtrlIn2),
  .railCtrlIn3SleepN(railCtrlIn3SleepN), .railCtrlIn4Prog(railCtrlIn4Prog),
  .railCtrlIn5(railCtrlIn5), .regEnable(regEnable), .regSleep(regSleep),
  .regSleepVolt(regSleepVolt), .gpOutput4OdOut(gpOutput4OdOut),
  .interruptOutNOut(interruptOutNOut), .interruptOutNOe(interruptOutNOe));

`default_nettype wire

//--- test/rcp_rail_pins_tb_top.sv
// Self-checking bench of the rail pin logic
`timescale 1ns/1ps
`default_nettype none
`include "rcp_cfg.svh"

// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module rcp_rail_pins_tb_top;
  import rcp_pkg::*;
  logic       sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, pg, regEn, regSlp, regVolt;
  rcp_word_t  pwdata, prdata, rdData;
  logic       in2, in3n, in5, rdErr, irqOut, irqOe;
  wire logic  irqLevel, progLevel, extRegEn;
  wire logic [3:0] gpOut, gpOe, gpLevel;
  int         errors, samples_checked, cycles;

  rcp_rail_pins #(.N(8), .AW(8)) dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .railCtrlIn2(in2),
    .railCtrlIn3SleepN(in3n), .railCtrlIn4Prog(progLevel),
    .railCtrlIn5(in5), .regPowerGood(pg), .regEnable(regEn),
    .regSleep(regSlp), .regSleepVolt(regVolt),
    .gpOutput1In(gpLevel[0]), .gpOutput1Out(gpOut[0]), .gpOutput1Oe(gpOe[0]),
    .gpOutput2In(gpLevel[1]), .gpOutput2Out(gpOut[1]), .gpOutput2Oe(gpOe[1]),
    .gpOutput3In(gpLevel[2]), .gpOutput3Out(gpOut[2]), .gpOutput3Oe(gpOe[2]),
    .gpOutput4OdIn(gpLevel[3]), .gpOutput4OdOut(gpOut[3]),
    .gpOutput4OdOe(gpOe[3]), .interruptOutNIn(irqLevel),
    .interruptOutNOut(irqOut), .interruptOutNOe(irqOe));

  rcp_pin_host u_host (
    .gpOut(gpOut), .gpOe(gpOe), .irqOut(irqOut), .irqOe(irqOe),
    .gpLevel(gpLevel), .irqLevel(irqLevel), .progLevel(progLevel),
    .extRegEn(extRegEn));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Hang guard, far above the roughly 115 cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report;
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input rcp_word_t seen, input rcp_word_t exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input rcp_word_t d);
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    // Taken at the completing edge, before its register updates
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : cyc

  task automatic testRegs;
    apb(1'b1, `RCP_OFF_GPOCFG, 32'h0000_0F5F);
    apb(1'b0, `RCP_OFF_GPOCFG, '0);
    check(rdData, 32'h0000_0F5F);
    apb(1'b1, `RCP_OFF_GPOCFG, 32'h0000_0000);
    apb(1'b0, 8'h3C, '0);
    check(rdData, 32'h0000_0000);
    check(rdErr, 1'b1);
  endtask : testRegs

  task automatic testRails;
    logic [3:0] s2 = 4'b0011;
    logic [3:0] s5 = 4'b0110;
    logic [7:0] e [4] = '{8'h03, 8'h33, 8'h30, 8'h00};
    apb(1'b1, `RCP_OFF_CTLMAP0, 32'h0000_0003);
    apb(1'b1, `RCP_OFF_CTLMAP3, 32'h0000_0030);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      in2 <= s2[i];
      in5 <= s5[i];
      cyc(1);
      check(regEn, e[i]);
    end
  endtask : testRails

  task automatic testSleep;
    apb(1'b1, `RCP_OFF_SLPCFG, 32'h0000_0001);
    apb(1'b1, `RCP_OFF_CTLMAP0 + 8'h04, 32'h0000_000C);
    apb(1'b1, `RCP_OFF_SLPMAP, 32'h0000_000C);
    apb(1'b1, `RCP_OFF_SLPVSEL, 32'h0000_0004);
    apb(1'b1, `RCP_OFF_IRQMASK, 32'h0000_0100);
    cyc(2);
    check(regEn, 8'h00);
    @(posedge sys_clk);
    in3n <= 1'b0;
    cyc(3);
    check(regSlp, 8'h0C);
    check(regVolt, 8'h04);
    check(irqLevel, 1'b0);
    // Status word: pins released high, interrupt pin pulled low
    apb(1'b0, `RCP_OFF_STATUS, '0);
    check(rdData, 32'h0F0C_00FF);
    apb(1'b0, `RCP_OFF_IRQSTAT, '0);
    check(rdData, 32'h0000_0100);
    cyc(2);
    check(irqLevel, 1'b1);
    @(posedge sys_clk);
    in3n <= 1'b1;
    cyc(3);
    check(regSlp, 8'h00);
    check(irqLevel, 1'b1);
    apb(1'b0, `RCP_OFF_IRQSTAT, '0);
    check(rdData, 32'h0000_0200);
  endtask : testSleep

  task automatic testGpo;
    logic [7:0] pgSet [3] = '{8'hFF, 8'hFD, 8'h7F};
    logic [3:0] lvl [3] = '{4'hF, 4'hE, 4'h7};
    logic [3:0] user;
    logic       drive;
    apb(1'b1, `RCP_OFF_PGMASK0, 32'h0000_0003);
    apb(1'b1, `RCP_OFF_PGMASK3, 32'h0000_00F0);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      pg <= pgSet[i];
      cyc(3);
      check(gpLevel, lvl[i]);
    end
    apb(1'b0, `RCP_OFF_IRQSTAT, '0);
    check(rdData, 32'h0000_0082);
    // Push-pull bit 7 is set too; output four must stay open-drain
    for (int m = 0; m < 4; m++) begin
      user = m[1] ? 4'b0101 : 4'b1010;
      apb(1'b1, `RCP_OFF_GPOCFG, {20'h0, user, m[0] ? 4'hF : 4'h0, 4'hF});
      cyc(2);
      check(extRegEn, user[0]);
      for (int k = 0; k < 4; k++) begin
        drive = m[0] && k < 3;
        check(gpOe[k], drive ? 1'b1 : !user[k]);
        check(gpOut[k], drive ? user[k] : 1'b0);
        check(gpLevel[k], user[k]);
      end
    end
  endtask : testGpo

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pg = 8'hFF;
    in2 = 1'b0;
    in3n = 1'b1;
    in5 = 1'b0;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    testRegs();
    testRails();
    testSleep();
    testGpo();
    final_report();
  end
endmodule : rcp_rail_pins_tb_top

`default_nettype wire
